// ### spc_pkg.sv
// package for the speed profile configuration register bank
// assumes a single clock domain and a 32-bit avalon-mm register bus
package spc_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int          SPC_DW       = 32;      // bus data width
   localparam int          SPC_AW       = 10;      // byte address width
   localparam int          SPC_NREG     = 4;       // registers in the bank
   localparam logic [1:0]  SPC_LANE_OK  = 2'h0;    // word aligned low bits

   // register indices; the byte address is four times the index
   localparam logic [7:0]  SPC_IDX_MODE_DUTY1 = 8'h94;
   localparam logic [7:0]  SPC_IDX_CURVE_DUTY = 8'h96;
   localparam logic [7:0]  SPC_IDX_DUTY2      = 8'h98;
   localparam logic [7:0]  SPC_IDX_RATE1      = 8'h9A;

   // ************************************************************
   // field positions (lsb) and widths
   // ************************************************************
   localparam int SPC_PAR_BIT     = 31;   // parity bit, every register
   localparam int SPC_MODE_LSB    = 29;   // profile mode, register 0
   localparam int SPC_ON1_LSB     = 21;
   localparam int SPC_OFF1_LSB    = 13;
   localparam int SPC_CLAMP1_LSB  = 5;
   localparam int SPC_AHI_LSB     = 0;    // point a upper five bits
   localparam int SPC_ALO_LSB     = 28;   // point a lower three bits, reg 1
   localparam int SPC_B_LSB       = 20;
   localparam int SPC_C_LSB       = 12;
   localparam int SPC_D_LSB       = 4;
   localparam int SPC_EHI_LSB     = 0;    // point e upper four bits, reg 1
   localparam int SPC_ELO_LSB     = 27;   // point e lower four bits, reg 2
   localparam int SPC_ON2_LSB     = 19;
   localparam int SPC_OFF2_LSB    = 11;
   localparam int SPC_CLAMP2_LSB  = 3;
   localparam int SPC_STOPR_LSB   = 23;   // stop rate, register 3
   localparam int SPC_CLAMPR_LSB  = 15;
   localparam int SPC_RATEA_LSB   = 7;
   localparam int SPC_BHI_LSB     = 0;    // point b rate upper seven bits
   localparam int SPC_FULL_SCALE  = 255;  // fractions are value over 255
   localparam int SPC_MAXHZ_W     = 14;   // maximum speed reference width

   // reset value of every register in the bank
   localparam logic [31:0] SPC_REG_RST = 32'h0000_0000;
   localparam logic [31:0] SPC_RD_UNMAPPED = 32'h0000_0000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      SPC_MODE_REF       = 2'b00,   // speed reference
      SPC_MODE_LINEAR    = 2'b01,
      SPC_MODE_STAIR     = 2'b10,
      SPC_MODE_FWD_REV   = 2'b11
   } spc_mode_t;

   // decoded configuration handed to the profile logic
   typedef struct packed {
      spc_mode_t   mode;
      logic [7:0]  start_duty_level_1;
      logic [7:0]  stop_duty_level_1;
      logic [7:0]  clamp_duty_level_1;
      logic [7:0]  start_duty_level_2;
      logic [7:0]  stop_duty_level_2;
      logic [7:0]  clamp_duty_level_2;
      logic [7:0]  duty_a;
      logic [7:0]  duty_b;
      logic [7:0]  duty_c;
      logic [7:0]  duty_d;
      logic [7:0]  duty_e;
      logic [7:0]  stop_rate_level_1;
      logic [7:0]  clamp_rate_level_1;
      logic [7:0]  rate_a;
      logic [6:0]  rate_b_hi;
   } spc_cfg_t;

   // avalon-mm request from the master
   typedef struct packed {
      logic [SPC_AW-1:0] address;
      logic              read;
      logic              write;
      logic [SPC_DW-1:0] writedata;
   } spc_avreq_t;

   // byte address of a printed register index
   function automatic logic [SPC_AW-1:0] spc_byte_addr(logic [7:0] idx);
      spc_byte_addr = {idx, SPC_LANE_OK};
   endfunction

endpackage

// ### spc_bus_slave.sv
// avalon-mm handshake for the register bank: one wait state per access
// assumes the master holds its request until it sees waitrequest low
module spc_bus_slave
   import spc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // request from the bus
   input  wire logic              req_read,
   input  wire logic              req_write,
   // read value of the addressed register, from the bank
   input  wire logic [SPC_DW-1:0] rd_value,
   // answer to the bus
   output logic                   waitrequest,
   output logic [SPC_DW-1:0]      readdata,
   // access taken this cycle
   output logic                   take
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic              ack;     // second cycle of an access
      logic [SPC_DW-1:0] rdata;   // captured read data
   } spc_bs_state_t;

   spc_bs_state_t st_r;   // registered state
   spc_bs_state_t st_nxt; // next state

   // ack rises one cycle after a request, then drops with the take
   always_comb
   begin
      st_nxt = st_r;
      if ((req_read || req_write) && !st_r.ack)
      begin
         // first cycle: latch the read value, answer next cycle
         st_nxt.ack   = 1'b1;
         st_nxt.rdata = req_read ? rd_value : st_r.rdata;
      end
      else
      begin
         // answer cycle or idle
         st_nxt.ack = 1'b0;
      end
   end

   // register the state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign waitrequest = (req_read || req_write) && !st_r.ack;
   assign readdata    = st_r.rdata;
   assign take        = (req_read || req_write) && st_r.ack;

   // ************************************************************
   // checks
   // ************************************************************
   a_wait_one_cycle : assert property (@(posedge clk) disable iff (rst)
      (req_read || req_write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait state");

endmodule

// ### spc_rate_scale.sv
// scales an 8-bit fraction of full scale against the maximum speed
// assumes the maximum speed reference is a stable 14-bit value in hz
module spc_rate_scale
   import spc_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // fraction and reference
   input  wire logic [7:0]             frac,
   input  wire logic [SPC_MAXHZ_W-1:0] max_hz,
   // scaled rate in hz, registered
   output logic [SPC_MAXHZ_W-1:0]      rate_hz
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [SPC_MAXHZ_W-1:0] hz;   // scaled result
   } spc_rs_state_t;

   spc_rs_state_t st_r;   // registered state
   spc_rs_state_t st_nxt; // next state

   // product is at most 255 times max, so the quotient fits 14 bits
   always_comb
   begin
      logic [21:0] prod;
      prod      = 22'(frac) * 22'(max_hz);
      st_nxt.hz = SPC_MAXHZ_W'(prod / 22'(SPC_FULL_SCALE));
   end

   // register the result
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rate_hz = st_r.hz;

endmodule

// ### spc_regs.sv
// speed profile configuration register bank, top level
// assumes an avalon-mm master with waitrequest and a 20 mhz clock;
// the maximum speed reference comes from another register bank
//
// The Avalon-MM slave port was decided locally.
module spc_regs
   import spc_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // avalon-mm slave
   input  wire logic [SPC_AW-1:0]      avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [SPC_DW-1:0]      avs_writedata,
   output logic                        avs_waitrequest,
   output logic [SPC_DW-1:0]           avs_readdata,
   // maximum speed reference in hz
   input  wire logic [SPC_MAXHZ_W-1:0] max_speed_hz,
   // decoded configuration
   output spc_cfg_t                    cfg,
   // stop and clamp rates of range one, in hz
   output logic [SPC_MAXHZ_W-1:0]      stop_rate_hz,
   output logic [SPC_MAXHZ_W-1:0]      clamp_rate_hz
);

   // ************************************************************
   // address decode
   // ************************************************************
   // register number of a byte address, or SPC_NREG when unmapped
   function automatic logic [2:0] spc_sel(logic [SPC_AW-1:0] a);
      if (a == spc_byte_addr(SPC_IDX_MODE_DUTY1))
         spc_sel = 3'h0;
      else if (a == spc_byte_addr(SPC_IDX_CURVE_DUTY))
         spc_sel = 3'h1;
      else if (a == spc_byte_addr(SPC_IDX_DUTY2))
         spc_sel = 3'h2;
      else if (a == spc_byte_addr(SPC_IDX_RATE1))
         spc_sel = 3'h3;
      else
         spc_sel = 3'(SPC_NREG);
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [SPC_NREG-1:0][SPC_DW-1:0] regs;   // the four registers
   } spc_state_t;

   spc_state_t        st_r;      // registered state
   spc_state_t        st_nxt;    // next state
   logic [2:0]        sel;       // decoded register number
   logic              mapped;    // address hits the bank
   logic [SPC_DW-1:0] rd_value;  // value of the addressed register
   logic              take;      // access completes this cycle
   spc_avreq_t        req;       // bundled request

   assign req.address   = avs_address;
   assign req.read      = avs_read;
   assign req.write     = avs_write;
   assign req.writedata = avs_writedata;

   assign sel    = spc_sel(req.address);
   assign mapped = (sel != 3'(SPC_NREG));

   // read mux: plain selection, no side effect on any register
   always_comb
   begin
      if (mapped)
      begin
         rd_value = st_r.regs[sel[1:0]];
      end
      else
      begin
         rd_value = SPC_RD_UNMAPPED;        // unmapped reads as zero
      end
   end

   // ************************************************************
   // bus handshake
   // ************************************************************
   spc_bus_slave u_bus (
      .clk         (clk),
      .rst         (rst),
      .req_read    (req.read),
      .req_write   (req.write),
      .rd_value    (rd_value),
      .waitrequest (avs_waitrequest),
      .readdata    (avs_readdata),
      .take        (take)
   );

   // ************************************************************
   // register write
   // ************************************************************
   // whole-word write on the answering cycle; every bit is stored,
   // parity and reserved bits included, so readback is exact
   always_comb
   begin
      st_nxt = st_r;
      if (take && req.write && mapped)
      begin
         st_nxt.regs[sel[1:0]] = req.writedata;
      end
   end

   // register the state; the whole bank clears so that mode, parity,
   // point e upper bits and reserved bits start at zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r.regs <= {SPC_NREG{SPC_REG_RST}};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // field decode
   // ************************************************************
   // fields are slices of the flops, so the outputs come from flops
   always_comb
   begin
      logic [SPC_DW-1:0] r0;
      logic [SPC_DW-1:0] r1;
      logic [SPC_DW-1:0] r2;
      logic [SPC_DW-1:0] r3;
      r0 = st_r.regs[0];
      r1 = st_r.regs[1];
      r2 = st_r.regs[2];
      r3 = st_r.regs[3];
      // profile mode select
      cfg.mode = spc_mode_t'(r0[SPC_MODE_LSB +: 2]);
      // range one thresholds
      cfg.start_duty_level_1 = r0[SPC_ON1_LSB +: 8];
      cfg.stop_duty_level_1  = r0[SPC_OFF1_LSB +: 8];
      cfg.clamp_duty_level_1 = r0[SPC_CLAMP1_LSB +: 8];
      // point a: upper five in register 0, lower three in register 1
      cfg.duty_a = {r0[SPC_AHI_LSB +: 5], r1[SPC_ALO_LSB +: 3]};
      // points b to d
      cfg.duty_b = r1[SPC_B_LSB +: 8];
      cfg.duty_c = r1[SPC_C_LSB +: 8];
      cfg.duty_d = r1[SPC_D_LSB +: 8];
      // point e: upper four in register 1, lower four in register 2
      cfg.duty_e = {r1[SPC_EHI_LSB +: 4], r2[SPC_ELO_LSB +: 4]};
      // range two thresholds
      cfg.start_duty_level_2 = r2[SPC_ON2_LSB +: 8];
      cfg.stop_duty_level_2  = r2[SPC_OFF2_LSB +: 8];
      cfg.clamp_duty_level_2 = r2[SPC_CLAMP2_LSB +: 8];
      // range one rates and curve rates
      cfg.stop_rate_level_1  = r3[SPC_STOPR_LSB +: 8];
      cfg.clamp_rate_level_1 = r3[SPC_CLAMPR_LSB +: 8];
      cfg.rate_a             = r3[SPC_RATEA_LSB +: 8];
      cfg.rate_b_hi          = r3[SPC_BHI_LSB +: 7];
   end

   // ************************************************************
   // rate scaling
   // ************************************************************
   // stop rate as a fraction of the maximum speed reference
   spc_rate_scale u_stop (
      .clk     (clk),
      .rst     (rst),
      .frac    (cfg.stop_rate_level_1),
      .max_hz  (max_speed_hz),
      .rate_hz (stop_rate_hz)
   );

   // clamp rate as a fraction of the maximum speed reference
   spc_rate_scale u_clamp (
      .clk     (clk),
      .rst     (rst),
      .frac    (cfg.clamp_rate_level_1),
      .max_hz  (max_speed_hz),
      .rate_hz (clamp_rate_hz)
   );

   // ************************************************************
   // checks
   // ************************************************************
   // reset leaves mode, parity, point e upper and reserved bits at zero
   a_reset_clear : assert property (@(posedge clk)
      rst |=> (cfg.mode == SPC_MODE_REF) && !st_r.regs[0][SPC_PAR_BIT]
              && (st_r.regs[1][SPC_EHI_LSB +: 4] == 4'h0)
              && (st_r.regs[2][2:0] == 3'h0))
      else $error("bank not cleared by reset");

   // point e upper bits read zero right after reset
   a_point_e_rst : assert property (@(posedge clk)
      $fell(rst) |-> cfg.duty_e[7:4] == 4'h0)
      else $error("point e upper bits not zero after reset");

   // a taken write lands in its register at the next cycle
   a_write_lands : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && mapped
      |=> st_r.regs[$past(sel[1:0])] == $past(avs_writedata))
      else $error("written word not stored");

   // a taken read returns the addressed register
   a_read_back : assert property (@(posedge clk) disable iff (rst)
      take && avs_read && mapped
      |-> avs_readdata == st_r.regs[sel[1:0]])
      else $error("read data differs from register");

   // reads never disturb the bank
   a_read_quiet : assert property (@(posedge clk) disable iff (rst)
      avs_read |=> $stable(st_r.regs))
      else $error("read changed a register");

   // unmapped reads answer zero
   a_unmapped_zero : assert property (@(posedge clk) disable iff (rst)
      take && avs_read && !mapped |-> avs_readdata == SPC_RD_UNMAPPED)
      else $error("unmapped read not zero");

   // point a lower three bits come from register 1 bits 30-28
   a_point_a_join : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h1)
      |=> cfg.duty_a[2:0] == $past(avs_writedata[SPC_ALO_LSB +: 3]))
      else $error("point a lower bits wrong");

   // point e lower half comes from register 2 bits 30-27
   a_point_e_join : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h2)
      |=> cfg.duty_e[3:0] == $past(avs_writedata[SPC_ELO_LSB +: 4]))
      else $error("point e lower bits wrong");

   // mode follows a write to register 0
   a_mode_update : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h0)
      |=> cfg.mode == spc_mode_t'($past(avs_writedata[SPC_MODE_LSB +: 2])))
      else $error("mode not taken from write");

   // the scaled stop rate never exceeds the reference
   a_rate_bound : assert property (@(posedge clk) disable iff (rst)
      $stable(max_speed_hz) |=> stop_rate_hz <= $past(max_speed_hz))
      else $error("scaled rate above maximum");

   // range one thresholds follow a write to register 0
   a_range_one : assert property (@(posedge clk)
      disable iff (rst) take && avs_write && (sel == 3'h0)
      |=> cfg.start_duty_level_1 == $past(avs_writedata[SPC_ON1_LSB +: 8])
      && cfg.stop_duty_level_1 == $past(avs_writedata[SPC_OFF1_LSB +: 8])
      && cfg.clamp_duty_level_1 == $past(avs_writedata[SPC_CLAMP1_LSB +: 8]))
      else $error("range one thresholds wrong");

   // points b to d follow a write to register 1
   a_curve_duty : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h1)
      |=> cfg.duty_b == $past(avs_writedata[SPC_B_LSB +: 8])
      && cfg.duty_c == $past(avs_writedata[SPC_C_LSB +: 8])
      && cfg.duty_d == $past(avs_writedata[SPC_D_LSB +: 8]))
      else $error("curve point duties wrong");

   // point e upper half comes from register 1 bits 3-0
   a_point_e_high : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h1)
      |=> cfg.duty_e[7:4] == $past(avs_writedata[SPC_EHI_LSB +: 4]))
      else $error("point e upper bits wrong");

   // range two thresholds follow a write to register 2
   a_range_two : assert property (@(posedge clk)
      disable iff (rst) take && avs_write && (sel == 3'h2)
      |=> cfg.start_duty_level_2 == $past(avs_writedata[SPC_ON2_LSB +: 8])
      && cfg.stop_duty_level_2 == $past(avs_writedata[SPC_OFF2_LSB +: 8])
      && cfg.clamp_duty_level_2 == $past(avs_writedata[SPC_CLAMP2_LSB +: 8]))
      else $error("range two thresholds wrong");

   // rate levels follow a write to register 3
   a_rate_fields : assert property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h3)
      |=> cfg.stop_rate_level_1 == $past(avs_writedata[SPC_STOPR_LSB +: 8])
      && cfg.clamp_rate_level_1 == $past(avs_writedata[SPC_CLAMPR_LSB +: 8])
      && cfg.rate_a == $past(avs_writedata[SPC_RATEA_LSB +: 8])
      && cfg.rate_b_hi == $past(avs_writedata[SPC_BHI_LSB +: 7]))
      else $error("rate levels wrong");

   // the clamp rate obeys the same ceiling
   a_clamp_bound : assert property (@(posedge clk) disable iff (rst)
      $stable(max_speed_hz) |=> clamp_rate_hz <= $past(max_speed_hz))
      else $error("scaled clamp rate above maximum");

   // main scenarios
   c_write_curve : cover property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h1));
   c_write_mode : cover property (@(posedge clk) disable iff (rst)
      take && avs_write && (sel == 3'h0));
   c_read_rates : cover property (@(posedge clk) disable iff (rst)
      take && avs_read && (sel == 3'h3));
   c_unmapped : cover property (@(posedge clk) disable iff (rst)
      take && !mapped);
   c_fwd_rev : cover property (@(posedge clk) disable iff (rst)
      cfg.mode == SPC_MODE_FWD_REV);

endmodule

// ### tb_spc_regs.sv
// testbench for the speed profile configuration register bank
// assumes spc_pkg and spc_regs are compiled first; one 20 mhz clock
module tb_spc_regs
   import spc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // signals
   // ************************************************************
   logic                   clk;            // 50 ns period
   logic                   rst;            // synchronous, active high
   logic [SPC_AW-1:0]      avs_address;    // byte address
   logic                   avs_read;       // read request
   logic                   avs_write;      // write request
   logic [SPC_DW-1:0]      avs_writedata;  // write word
   logic                   avs_waitrequest;
   logic [SPC_DW-1:0]      avs_readdata;
   logic [SPC_MAXHZ_W-1:0] max_speed_hz;   // speed reference input
   spc_cfg_t               cfg;            // decoded fields
   logic [SPC_MAXHZ_W-1:0] stop_rate_hz;
   logic [SPC_MAXHZ_W-1:0] clamp_rate_hz;
   int                     num_errors;     // mismatches
   int                     compares;       // comparisons made
   logic [31:0]            w [4];          // words written per register
   logic [SPC_AW-1:0]      a [4];          // byte addresses of registers

   // device under test
   spc_regs uut
   (
      .clk             (clk),
      .rst             (rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_waitrequest (avs_waitrequest),
      .avs_readdata    (avs_readdata),
      .max_speed_hz    (max_speed_hz),
      .cfg             (cfg),
      .stop_rate_hz    (stop_rate_hz),
      .clamp_rate_hz   (clamp_rate_hz)
   );

   // ************************************************************
   // tasks
   // ************************************************************
   // verdict and end of run, the only exit
   task end_sim();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one comparison, counted and reported
   task chk(input logic [31:0] got, input logic [31:0] exp,
            input string what);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h",
                  $time, what, got, exp);
      end
   endtask

   // one avalon access: raised after an edge, held until the edge at
   // which waitrequest is sampled low, data taken and released there
   task bus_xfer(input logic is_wr, input logic [SPC_AW-1:0] adr,
                 input logic [31:0] din, output logic [31:0] dout);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= adr;
      avs_read      <= !is_wr;
      avs_write     <= is_wr;
      avs_writedata <= din;
      @(posedge clk);
      // wait states: waitrequest is seen as it stood before this edge
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         chk(32'h1, 32'h0, "bus answer missing");
      dout = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // register write
   task wr(input logic [SPC_AW-1:0] adr, input logic [31:0] d);
      logic [31:0] x;
      bus_xfer(1'b1, adr, d, x);
   endtask

   // register read with expected word
   task rdchk(input logic [SPC_AW-1:0] adr, input logic [31:0] e,
              input string what);
      logic [31:0] x;
      bus_xfer(1'b0, adr, 32'h0000_0000, x);
      chk(x, e, what);
   endtask

   // rate outputs against floor of level times max over full scale
   task rate_chk();
      logic [31:0] e_stop;
      logic [31:0] e_clamp;
      repeat (2) @(negedge clk);
      e_stop  = (32'(w[3][30:23]) * 32'(max_speed_hz)) / 32'h0000_00FF;
      e_clamp = (32'(w[3][22:15]) * 32'(max_speed_hz)) / 32'h0000_00FF;
      chk(32'(stop_rate_hz), e_stop, "stop rate");
      chk(32'(clamp_rate_hz), e_clamp, "clamp rate");
   endtask

   // ************************************************************
   // clock and watchdog
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // run needs about 110 cycles; cut a hang at 3000
   initial
   begin
      repeat (3000) @(posedge clk);
      num_errors++;
      end_sim();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      max_speed_hz = 14'h2710;
      num_errors = 0;
      compares = 0;
      a[0] = {SPC_IDX_MODE_DUTY1, 2'h0};
      a[1] = {SPC_IDX_CURVE_DUTY, 2'h0};
      a[2] = {SPC_IDX_DUTY2, 2'h0};
      a[3] = {SPC_IDX_RATE1, 2'h0};
      w[0] = {1'b1, 2'h2, 8'hA5, 8'h3C, 8'hC3, 5'h15};
      w[1] = 32'hD6B7_C8E9;
      w[2] = 32'hFEDC_BA97;
      w[3] = 32'h7FAD_4321;          // stop level at full scale
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // reset values of every word and of split point e
      for (int i = 0; i < 4; i++)
         rdchk(a[i], 32'h0000_0000, "reset word");
      chk(32'(cfg.duty_e), 32'h0000_0000, "point e reset");
      // write all, read back twice: no side effect of reads
      for (int i = 0; i < 4; i++)
         wr(a[i], w[i]);
      for (int k = 0; k < 8; k++)
         rdchk(a[k % 4], w[k % 4], "read back");
      @(negedge clk);
      chk(32'(cfg.mode), 32'(w[0][30:29]), "mode");
      chk(32'(cfg.start_duty_level_1), 32'(w[0][28:21]), "on1");
      chk(32'(cfg.stop_duty_level_1), 32'(w[0][20:13]), "off1");
      chk(32'(cfg.clamp_duty_level_1), 32'(w[0][12:5]), "cl1");
      chk(32'(cfg.duty_a), {24'h0, w[0][4:0], w[1][30:28]}, "a");
      chk(32'(cfg.duty_b), 32'(w[1][27:20]), "b");
      chk(32'(cfg.duty_c), 32'(w[1][19:12]), "c");
      chk(32'(cfg.duty_d), 32'(w[1][11:4]), "d");
      chk(32'(cfg.duty_e), {24'h0, w[1][3:0], w[2][30:27]}, "e");
      chk(32'(cfg.start_duty_level_2), 32'(w[2][26:19]), "on2");
      chk(32'(cfg.stop_duty_level_2), 32'(w[2][18:11]), "off2");
      chk(32'(cfg.clamp_duty_level_2), 32'(w[2][10:3]), "cl2");
      chk(32'(cfg.stop_rate_level_1), 32'(w[3][30:23]), "sr");
      chk(32'(cfg.clamp_rate_level_1), 32'(w[3][22:15]), "cr");
      chk(32'(cfg.rate_a), 32'(w[3][14:7]), "ra");
      chk(32'(cfg.rate_b_hi), 32'(w[3][6:0]), "rb");
      // scaled rates, then a new reference
      rate_chk();
      @(posedge clk);
      max_speed_hz <= 14'h3FFF;
      rate_chk();
      // every profile mode, rest of the word kept
      for (int m = 0; m < 4; m++)
      begin
         w[0][30:29] = 2'(m);
         wr(a[0], w[0]);
         @(negedge clk);
         chk(32'(cfg.mode), 32'(m), "mode select");
         rdchk(a[0], w[0], "mode word");
      end
      // unmapped and misaligned: read zero, write ignored
      wr({SPC_IDX_MODE_DUTY1, 2'h1}, 32'hFFFF_FFFF);
      rdchk(a[0], w[0], "misaligned write");
      rdchk({SPC_IDX_MODE_DUTY1, 2'h2}, 32'h0000_0000, "misaligned");
      rdchk({8'h95, 2'h0}, 32'h0000_0000, "gap index");
      rdchk(10'h000, 32'h0000_0000, "unmapped");
      // second reset in mid-run clears every word
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         rdchk(a[i], 32'h0000_0000, "second reset");
      end_sim();
   end
endmodule
